// ===== burst_pkg.sv
package burst_pkg;
   // register byte offsets
   localparam logic [7:0] A_MODE = 8'h00;
   localparam logic [7:0] A_DLL  = 8'h04;
   localparam logic [7:0] A_SRA  = 8'h08;
   localparam logic [7:0] A_CRC  = 8'h0c;
   localparam logic [7:0] A_XSF  = 8'h10;
   localparam logic [7:0] A_XSA  = 8'h14;
   localparam logic [7:0] A_XS   = 8'h18;
   localparam logic [7:0] A_STAT = 8'h1c;
   localparam logic [7:0] A_REFC = 8'h20;
   localparam logic [7:0] A_NONE = 8'hff;
   // field positions
   localparam int BL_LSB    = 0;
   localparam int BT_BIT    = 3;
   localparam int DLL_BIT   = 0;
   localparam int ABORT_BIT = 9;
   localparam int CRC_BIT   = 0;
   // burst length codes
   localparam logic [1:0] BL_BL8 = 2'h0;
   localparam logic [1:0] BL_OTF = 2'h1;
   localparam logic [1:0] BL_BC4 = 2'h2;
   // reset values
   localparam logic [1:0]  RST_BL  = BL_BL8;
   localparam logic        RST_DLL = 1'b1;
   localparam logic [15:0] RST_XSF = 16'h0010;
   localparam logic [15:0] RST_XSA = 16'h0020;
   localparam logic [15:0] RST_XS  = 16'h0040;
   // timing counts in hclk cycles
   localparam int WR_LAT_DEF  = 8;
   localparam int WR_PULL_IN  = 2;
   localparam int REF_PER_DEF = 64;
   localparam int REF_LEN_DEF = 16;

   typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_BURST = 1'b1} bst_t;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic       a12_bc;
      logic [2:0] col;
   } cmd_t;

   typedef struct packed {
      logic [2:0] col;
      logic       oe;
      logic       take;
   } beat_t;
endpackage : burst_pkg

// ===== burst_seq.sv
`timescale 1ns/1ps
`default_nettype none
module burst_seq (
   input  wire logic [2:0] start,  // starting column bits
   input  wire logic [2:0] beat,   // beat number
   input  wire logic       ilv,    // interleaved order
   output logic      [2:0] col     // column of this beat
);
   import burst_pkg::*;

   // sequential wraps inside the half, interleaved is a plain xor
   always_comb begin
      col = start ^ beat;
      if (!ilv) begin
         col[1:0] = 2'(start[1:0] + beat[1:0]);
      end
   end
endmodule : burst_seq
`default_nettype wire

// ===== exit_timer.sv
`timescale 1ns/1ps
`default_nettype none
module exit_timer #(
   parameter int W = 16            // counter width
) (
   input  wire logic         clk,   // clock
   input  wire logic         rst_n, // async reset, low
   input  wire logic         go,    // start counting
   input  wire logic         clr,   // drop done
   input  wire logic [W-1:0] len,   // delay in cycles
   output logic              done   // delay elapsed
);
   import burst_pkg::*;

   if (W < 2) begin : g_w_chk
      $error("exit_timer width too small");
   end

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         done;
      logic         run;
   } tst_t;
   tst_t q, d;

   // counts down only after a start; a clear parks it, so done cannot
   // come back up by itself while self refresh lasts
   always_comb begin
      d = q;
      if (go) begin
         d.cnt  = len;
         d.done = (len == '0);
         d.run  = 1'b1;
      end else if (clr) begin
         d.done = 1'b0;
         d.run  = 1'b0;
      end else if (q.run && !q.done) begin
         d.cnt  = W'(q.cnt - 1'b1);
         d.done = (q.cnt <= W'(1));
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '{cnt: '0, done: 1'b1, run: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign done = q.done;
endmodule : exit_timer
`default_nettype wire

// ===== burst_order_dll_switch.sv
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - mode bit 3 picks sequential or interleaved beat order
// - mode bits 1:0 pick fixed chop, fixed eight-beat or on-the-fly
// - on-the-fly: a12_bc low with the command chops, high gives eight beats
// - sequential reads wrap modulo four in the half, then the other half
// - beat 0 carries start column; interleaved column is start xor n
// - chopped reads drive data and strobe on beats 0-3 only
// - chopped writes use order 0-3 or 4-7 by bit 2; eight-beat writes 0-7
// - fixed chop starts the internal write two clocks earlier
// - on-the-fly chop starts the internal write like eight beats
// - write crc with fixed eight beats forces start column zero
// - dll bit zero turns the dll off until written back to one
// - abort enabled: refresh dropped uncounted, abort delay used at exit
module burst_order_dll_switch #(
   parameter int unsigned WR_LAT  = burst_pkg::WR_LAT_DEF,  // cycles to eight-beat write start
   parameter int unsigned REF_PER = burst_pkg::REF_PER_DEF, // self refresh period
   parameter int unsigned REF_LEN = burst_pkg::REF_LEN_DEF  // self refresh busy time
) (
   input  wire logic              hclk,      // bus clock
   input  wire logic              hresetn,   // async reset, low
   input  wire logic              hsel,      // slave select
   input  wire logic [31:0]       haddr,     // byte address
   input  wire logic [1:0]        htrans,    // transfer type
   input  wire logic              hwrite,    // write access
   input  wire logic [2:0]        hsize,     // word only
   input  wire logic [31:0]       hwdata,    // write data
   input  wire logic              hready,    // bus ready
   output logic                   hreadyout, // always ready
   output logic      [31:0]       hrdata,    // read data
   output logic                   hresp,     // always okay
   input  wire burst_pkg::cmd_t   cmd_i,     // read or write command
   input  wire logic              sre_i,     // self refresh entry
   input  wire logic              srx_i,     // self refresh exit
   output burst_pkg::beat_t       beat_o,    // beat column and strobes
   output logic                   wr_start,  // internal write start
   output logic                   dll_on,    // dll enabled
   output logic                   sr_active, // in self refresh
   output logic                   fast_ok,   // fast exit delay met
   output logic                   cmd_ok,    // normal or abort delay met
   output logic                   busy       // burst in progress
);
   import burst_pkg::*;

   localparam logic [3:0] LAT_BL8 = 4'(WR_LAT);
   localparam logic [3:0] LAT_BC4 = 4'(WR_LAT - WR_PULL_IN);
   localparam logic [15:0] PER16  = 16'(REF_PER - 1);
   localparam logic [15:0] LEN16  = 16'(REF_LEN);
   localparam int WS_BC4 = WR_LAT;
   localparam int WS_BL8 = WR_LAT + 2;

   // elaboration-time checks; the beat counter is only four bits wide
   if (WR_LAT < 7 || WR_LAT > 15) begin : g_lat_chk
      $error("WR_LAT must be 7 to 15");
   end
   if (REF_LEN < 1 || REF_LEN >= REF_PER) begin : g_len_chk
      $error("REF_LEN out of range");
   end
   if (REF_PER > 65535) begin : g_per_chk
      $error("REF_PER too large");
   end

   typedef struct packed {
      bst_t        st;
      logic [3:0]  cyc;
      logic        rd;
      logic        chop;
      logic        fixed;
      logic        ilv;
      logic [2:0]  start;
      logic [1:0]  bl;
      logic        bt;
      logic        dll;
      logic        abort;
      logic        crc;
      logic [15:0] xsf;
      logic [15:0] xsa;
      logic [15:0] xs;
      logic [15:0] refc;
      logic        sr;
      logic [15:0] rtmr;
      logic        wpend;
      logic [7:0]  waddr;
      logic        rdy;
      logic [31:0] rdata;
      logic [2:0]  ocol;
      logic        ooe;
      logic        otake;
      logic        wstart;
   } st_t;

   st_t         q, d;
   logic        take;
   logic        chop_c;
   logic        rbusy;
   logic        sr_go;
   logic        sr_in;
   logic [2:0]  seq_col;
   logic        f_done;
   logic        n_done;
   logic [15:0] n_len;

   ////////////////////////////////////////////////////////////////////
   // beat ordering and exit timers

   burst_seq u_seq (
      .start (q.start),
      .beat  (q.cyc[2:0]),
      .ilv   (q.ilv),
      .col   (seq_col)
   );

   // abort shortens the normal wait; the fast wait runs alongside
   assign n_len = q.abort ? q.xsa : q.xs;

   exit_timer #(.W(16)) u_fast (
      .clk   (hclk),
      .rst_n (hresetn),
      .go    (sr_go),
      .clr   (sr_in),
      .len   (q.xsf),
      .done  (f_done)
   );

   exit_timer #(.W(16)) u_norm (
      .clk   (hclk),
      .rst_n (hresetn),
      .go    (sr_go),
      .clr   (sr_in),
      .len   (n_len),
      .done  (n_done)
   );

   ////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      d      = q;
      take   = cmd_i.valid && q.st == ST_IDLE && !q.sr;
      rbusy  = q.sr && q.rtmr < LEN16;
      sr_in  = sre_i && !q.sr && q.st == ST_IDLE;
      sr_go  = srx_i && q.sr;
      chop_c = q.bl == BL_BC4 || (q.bl == BL_OTF && !cmd_i.a12_bc);

      // register writes land in the data phase
      d.wpend = 1'b0;
      if (q.wpend) begin
         if (q.waddr == A_MODE) begin
            d.bl = hwdata[BL_LSB +: 2];
            d.bt = hwdata[BT_BIT];
         end else if (q.waddr == A_DLL) begin
            d.dll = hwdata[DLL_BIT];
         end else if (q.waddr == A_SRA) begin
            d.abort = hwdata[ABORT_BIT];
         end else if (q.waddr == A_CRC) begin
            d.crc = hwdata[CRC_BIT];
         end else if (q.waddr == A_XSF) begin
            d.xsf = hwdata[15:0];
         end else if (q.waddr == A_XSA) begin
            d.xsa = hwdata[15:0];
         end else if (q.waddr == A_XS) begin
            d.xs = hwdata[15:0];
         end
      end

      // address phase; register reads see a write in flight, status reads do not
      if (hsel && htrans[1] && hready) begin
         d.wpend = hwrite;
         d.waddr = (haddr[31:8] == '0) ? haddr[7:0] : A_NONE;
         d.rdata = '0;
         if (hwrite) begin
            d.rdata = '0;
         end else if (haddr[31:8] != '0) begin
            d.rdata = '0;
         end else if (haddr[7:0] == A_MODE) begin
            d.rdata[BL_LSB +: 2] = d.bl;
            d.rdata[BT_BIT] = d.bt;
         end else if (haddr[7:0] == A_DLL) begin
            d.rdata[DLL_BIT] = d.dll;
         end else if (haddr[7:0] == A_SRA) begin
            d.rdata[ABORT_BIT] = d.abort;
         end else if (haddr[7:0] == A_CRC) begin
            d.rdata[CRC_BIT] = d.crc;
         end else if (haddr[7:0] == A_XSF) begin
            d.rdata[15:0] = d.xsf;
         end else if (haddr[7:0] == A_XSA) begin
            d.rdata[15:0] = d.xsa;
         end else if (haddr[7:0] == A_XS) begin
            d.rdata[15:0] = d.xs;
         end else if (haddr[7:0] == A_STAT) begin
            d.rdata[4:0] = {n_done, f_done, rbusy, q.sr, q.dll};
            d.rdata[5] = q.st == ST_BURST;
         end else if (haddr[7:0] == A_REFC) begin
            d.rdata[15:0] = q.refc;
         end
      end

      // self refresh; the internal refresh repeats every period
      if (sr_in) begin
         d.sr   = 1'b1;
         d.rtmr = '0;
      end else if (q.sr) begin
         d.rtmr = (q.rtmr == PER16) ? 16'h0000 : 16'(q.rtmr + 1'b1);
         if (srx_i) begin
            d.sr = 1'b0;
         end
      end
      // an aborted refresh is never counted; otherwise exit completes it
      if (rbusy && !(srx_i && q.abort) && (srx_i || q.rtmr == 16'(LEN16 - 1'b1))) begin
         d.refc = 16'(q.refc + 1'b1);
      end

      // burst engine, one beat per cycle
      d.ooe    = 1'b0;
      d.otake  = 1'b0;
      d.wstart = 1'b0;
      case (q.st)
         ST_IDLE: begin
            if (take) begin
               d.st    = ST_BURST;
               d.cyc   = 4'h0;
               d.rd    = !cmd_i.write;
               d.chop  = chop_c;
               d.fixed = q.bl == BL_BC4;
               d.ilv   = q.bt;
               if (!cmd_i.write) begin
                  d.start = cmd_i.col;
               end else if (chop_c) begin
                  d.start = {cmd_i.col[2], 2'b00};
               end else begin
                  d.start = 3'h0;
               end
            end
         end
         ST_BURST: begin
            d.ocol  = seq_col;
            // chopped bursts stay high impedance in the back half
            d.ooe   = q.rd && !q.cyc[3] && !(q.chop && q.cyc[2]);
            d.otake = !q.rd && !q.cyc[3] && !(q.chop && q.cyc[2]);
            // only a fixed chop pulls the internal write in
            d.wstart = !q.rd && q.cyc == (q.fixed ? LAT_BC4 : LAT_BL8);
            d.cyc   = 4'(q.cyc + 1'b1);
            if (q.rd ? q.cyc == 4'h7 : q.cyc == LAT_BL8) begin
               d.st = ST_IDLE;
            end
         end
         default: begin
            d.st = ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q       <= '0;
         q.st    <= ST_IDLE;
         q.bl    <= RST_BL;
         q.dll   <= RST_DLL;
         q.xsf   <= RST_XSF;
         q.xsa   <= RST_XSA;
         q.xs    <= RST_XS;
         q.rdy   <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // outputs, all from flops except hresp, which is tied low
   assign hreadyout   = q.rdy;
   assign hrdata      = q.rdata;
   assign hresp       = 1'b0;
   assign beat_o.col  = q.ocol;
   assign beat_o.oe   = q.ooe;
   assign beat_o.take = q.otake;
   assign wr_start    = q.wstart;
   assign dll_on      = q.dll;
   assign sr_active   = q.sr;
   assign fast_ok     = f_done;
   assign cmd_ok      = n_done;
   assign busy        = q.st == ST_BURST;

   ////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence wr_taken_s;
      take && cmd_i.write;
   endsequence

   sequence bc4_fixed_s;
      q.bl == BL_BC4;
   endsequence

   mode_order_a : assert property (q.st == ST_BURST && !q.ilv |->
      seq_col == {q.start[2] ^ q.cyc[2], 2'(q.start[1:0] + q.cyc[1:0])})
      else $error("sequential beat column wrong");
   ilv_order_a : assert property (q.st == ST_BURST && q.ilv && q.rd |->
      seq_col == (q.start ^ q.cyc[2:0]))
      else $error("interleaved beat column wrong");
   otf_chop_a : assert property (take && q.bl == BL_OTF |=>
      q.chop == !$past(cmd_i.a12_bc))
      else $error("on-the-fly chop not from a12_bc");
   fixed_len_a : assert property (take && q.bl == BL_BL8 |=> !q.chop)
      else $error("fixed eight beats chopped");
   chop_hiz_a : assert property (take && !cmd_i.write && chop_c
      |-> ##1 (q.st == ST_BURST) ##4 beat_o.oe ##1 !beat_o.oe [*4])
      else $error("chopped read drives back half");
   wr_order_a : assert property (wr_taken_s |=> q.start[1:0] == 2'b00)
      else $error("write start column not aligned");
   crc_zero_a : assert property (wr_taken_s and (q.crc && q.bl == BL_BL8) |=>
      q.start == 3'h0)
      else $error("crc write order not zero");
   bc4_start_a : assert property (wr_taken_s and bc4_fixed_s |-> ##WS_BC4 wr_start)
      else $error("fixed chop write start late");
   otf_start_a : assert property (wr_taken_s and (q.bl == BL_OTF) |->
      ##WS_BL8 wr_start)
      else $error("on-the-fly write start moved");
   dll_write_a : assert property (q.wpend && q.waddr == A_DLL |=>
      dll_on == $past(hwdata[DLL_BIT]))
      else $error("dll bit not taken");
   abort_cnt_a : assert property (sr_go && rbusy && q.abort |=>
      q.refc == $past(q.refc) && !sr_active)
      else $error("aborted refresh counted");
   exit_wait_a : assert property (sr_go && q.xs > 16'h0001 && !q.abort
      |=> !cmd_ok [*2])
      else $error("exit delay not honoured");
endmodule : burst_order_dll_switch
`default_nettype wire

// ===== ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// controller stand-in: issues commands and self refresh pulses, each one clock long
module ctl_model #(
   parameter int unsigned MOD_DLY = 4, // mode write settle before entry
   parameter int unsigned CKSRX   = 6  // stable clock before exit
) (
   input  wire logic       hclk,      // clock
   input  wire logic       busy,      // burst in progress
   input  wire logic       sr_active, // in self refresh
   input  wire logic       cmd_ok,    // exit delay met
   output burst_pkg::cmd_t cmd_o,     // command to device
   output logic            sre_o,     // self refresh entry
   output logic            srx_o      // self refresh exit
);
   import burst_pkg::*;

   initial begin
      cmd_o = '0;
      sre_o = 1'b0;
      srx_o = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // wait for an idle device; values read at the edge are the pre-edge ones
   task automatic wait_idle();
      @(posedge hclk);
      // idle, out of self refresh, normal or abort exit delay met before anything new
      while (busy !== 1'b0 || sr_active !== 1'b0 || cmd_ok !== 1'b1) begin
         @(posedge hclk);
      end
   endtask : wait_idle

   // polite command, one cycle wide, returns at the taking edge
   task automatic send_cmd(input logic wr, input logic a12, input logic [2:0] col);
      wait_idle();
      cmd_o <= '{valid: 1'b1, write: wr, a12_bc: a12, col: col};
      @(posedge hclk);
      cmd_o <= '0;
   endtask : send_cmd

   // rude command that ignores the device state, for refusal tests
   task automatic raw_cmd();
      @(posedge hclk);
      cmd_o <= '{valid: 1'b1, write: 1'b0, a12_bc: 1'b1, col: 3'h0};
      @(posedge hclk);
      cmd_o <= '0;
   endtask : raw_cmd

   task automatic enter_sr();
      wait_idle();
      repeat (MOD_DLY) @(posedge hclk);
      sre_o <= 1'b1;
      @(posedge hclk);
      sre_o <= 1'b0;
   endtask : enter_sr

   // the bench clock never stops, so the hold is only a count
   task automatic exit_sr();
      repeat (CKSRX) @(posedge hclk);
      // no clock enable or termination pins here: both stay parked by construction
      srx_o <= 1'b1;
      @(posedge hclk);
      srx_o <= 1'b0;
   endtask : exit_sr
endmodule : ctl_model
`default_nettype wire

// ===== tb_burst_order_dll_switch.sv
`timescale 1ns/1ps
`default_nettype none
module tb_burst_order_dll_switch;
   import burst_pkg::*;
   localparam int unsigned WLAT = 9;
   localparam int          XSF  = 5;
   localparam int          XSA  = 9;
   localparam int          XSN  = 14;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd, r0, r1;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   cmd_t        cmd;
   beat_t       beat;
   logic        sre, srx, wr_start, dll_on, sr_active, fast_ok, cmd_ok, busy;
   int          fail_count, total_checks, seed;

   burst_order_dll_switch #(.WR_LAT(WLAT), .REF_PER(8), .REF_LEN(2)) dut_u (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cmd_i(cmd), .sre_i(sre),
      .srx_i(srx), .beat_o(beat), .wr_start(wr_start), .dll_on(dll_on),
      .sr_active(sr_active), .fast_ok(fast_ok), .cmd_ok(cmd_ok), .busy(busy));

   ctl_model ctl_u (.hclk(hclk), .busy(busy), .sr_active(sr_active), .cmd_ok(cmd_ok),
      .cmd_o(cmd), .sre_o(sre), .srx_o(srx));

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test

   // single word transfer, held until ready is seen at an edge
   task automatic ahb_xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                           output logic [31:0] rdat);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= addr;
      htrans <= 2'b10;
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rdat = hrdata;
   endtask : ahb_xfer

   // expected column of beat k
   function automatic logic [2:0] exp_col(input logic wr, input logic ch, input logic ilv,
                                          input logic [2:0] s, input logic [2:0] k);
      if (wr)
         return ch ? {s[2], k[1:0]} : k;
      return ilv ? (s ^ k) : {s[2] ^ k[2], s[1:0] + k[1:0]};
   endfunction : exp_col

   ////////////////////////////////////////////////////////////////////////////////
   // one command; beats recorded per edge, then compared from the first live beat
   task automatic run_burst(input logic wr, input logic [1:0] bl, input logic ilv,
                            input logic a12, input logic [2:0] s);
      beat_t      hist [1:16];
      logic       chop, eo, et, ok;
      logic [2:0] ec;
      int         ws, base;
      chop = (bl == BL_BC4) || (bl == BL_OTF && !a12);
      // the start pulse shows one edge after its flop; a fixed chop is two earlier
      base = (bl == BL_BC4) ? WLAT - 1 : WLAT + 1;
      ws   = -1;
      ctl_u.send_cmd(wr, a12, s);
      for (int n = 1; n <= WLAT + 4; n++) begin
         @(posedge hclk);
         #1;
         hist[n] = beat;
         if (wr_start === 1'b1 && ws < 0) ws = n;
      end
      // beat zero stands right after the first edge past the take
      for (int k = 0; k < 8; k++) begin
         eo = !wr && !(chop && k >= 4);
         et = wr && !(chop && k >= 4);
         ec = exp_col(wr, chop, ilv, s, 3'(k));
         check("beat oe", 32'(eo), 32'(hist[k + 1].oe));
         check("beat take", 32'(et), 32'(hist[k + 1].take));
         if (eo || et)
            check("beat col", 32'(ec), 32'(hist[k + 1].col));
      end
      ok = wr ? (ws == base) : (ws < 0);
      check("write start", 32'h1, 32'(ok));
   endtask : run_burst

   // self refresh round trip, timing the exit delays
   task automatic sr_cycle(input logic abort);
      int nf, nc;
      nf = 0;
      nc = 0;
      ahb_xfer(1'b1, 32'(A_SRA), {22'h0, abort, 9'h0}, rd);
      ahb_xfer(1'b0, 32'(A_REFC), 32'h0, r0);
      ctl_u.enter_sr();
      repeat (2) @(posedge hclk);
      #1;
      check("sr active", 32'h1, 32'(sr_active));
      check("exit flags in sr", 32'h0, {30'h0, fast_ok, cmd_ok});
      ctl_u.raw_cmd();
      repeat (3) @(posedge hclk);
      #1;
      check("busy in sr", 32'h0, 32'(busy));
      repeat (40) @(posedge hclk);
      ahb_xfer(1'b0, 32'(A_REFC), 32'h0, r1);
      check("refresh runs", 32'h1, 32'(r1 > r0));
      ctl_u.exit_sr();
      for (int n = 1; n <= 200; n++) begin
         @(posedge hclk);
         #1;
         if (fast_ok === 1'b1 && nf == 0) nf = n;
         if (cmd_ok === 1'b1 && nc == 0) nc = n;
      end
      check("fast delay", 32'h1, 32'(nf == XSF));
      check("exit delay", 32'h1, 32'(nc == (abort ? XSA : XSN)));
   endtask : sr_cycle

   ////////////////////////////////////////////////////////////////////////////////
   localparam logic [31:0] RADDR [10] = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h10, 32'h14,
                                          32'h18, 32'h1c, 32'h20, 32'h100};
   localparam logic [31:0] RVAL [10]  = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h10, 32'h20,
                                          32'h40, 32'h19, 32'h0, 32'h0};

   initial begin
      fail_count   = 0;
      total_checks = 0;
      seed         = 37;
      hresetn      = 1'b0;
      hsel         = 1'b0;
      haddr        = 32'h0;
      htrans       = 2'b00;
      hwrite       = 1'b0;
      hsize        = 3'h2;
      hwdata       = 32'h0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      // reset values, unmapped place, read-only status
      for (int i = 0; i < 10; i++) begin
         ahb_xfer(1'b0, RADDR[i], 32'h0, rd);
         check("reset value", RVAL[i], rd);
      end
      ahb_xfer(1'b1, 32'h1c, 32'hffff_ffff, rd);
      ahb_xfer(1'b0, 32'h1c, 32'h0, rd);
      check("status ro", 32'h19, rd);
      check("hresp", 32'h0, 32'(hresp));
      check("hready", 32'h1, 32'(hreadyout));
      // every length code and order, both directions, random start column
      for (int rep = 0; rep < 2; rep++) begin
         for (int m = 0; m < 16; m++) begin
            ahb_xfer(1'b1, 32'h0, {28'h0, m[2], 1'b0, m[1:0]}, rd);
            ahb_xfer(1'b0, 32'h0, 32'h0, rd);
            check("mode", {28'h0, m[2], 1'b0, m[1:0]}, rd);
            run_burst(m[3], m[1:0], m[2], rep[0], 3'($random(seed)));
         end
      end
      // crc with fixed eight beats keeps the write order at zero
      ahb_xfer(1'b1, 32'hc, 32'h1, rd);
      ahb_xfer(1'b1, 32'h0, 32'h0, rd);
      run_burst(1'b1, BL_BL8, 1'b0, 1'b1, 3'h5);
      ahb_xfer(1'b1, 32'hc, 32'h0, rd);
      // dll off then back on
      ahb_xfer(1'b1, 32'h4, 32'h0, rd);
      ahb_xfer(1'b0, 32'h1c, 32'h0, rd);
      check("dll off", 32'h0, {31'h0, dll_on});
      check("status dll", 32'h0, {31'h0, rd[0]});
      ahb_xfer(1'b1, 32'h4, 32'h1, rd);
      ahb_xfer(1'b0, 32'h4, 32'h0, rd);
      check("dll on", 32'h1, {31'h0, dll_on});
      // self refresh, normal then abort exit
      ahb_xfer(1'b1, 32'h10, 32'(XSF), rd);
      ahb_xfer(1'b1, 32'h14, 32'(XSA), rd);
      ahb_xfer(1'b1, 32'h18, 32'(XSN), rd);
      sr_cycle(1'b0);
      sr_cycle(1'b1);
      run_burst(1'b0, BL_BL8, 1'b0, 1'b1, 3'h3);
      finish_test();
   end

   // hang guard at 30000 cycles, well beyond the under 1500 cycles above
   initial begin
      #3000000;
      fail_count++;
      finish_test();
   end
endmodule : tb_burst_order_dll_switch
`default_nettype wire
